//--- rtl/ctw_pkg.sv
// core timer package: register map, fields, reset values, timing
// Contract
// - overflow flag sets on low byte wrap
// - overflow request while flag and enable
// - one to overflow clear bit clears flag
// - periodic flag sets on tap; requests if enabled
// - one clears periodic flag; direct writes ignored
// - enables read/write; reset clears enables, flags
// - clear bits write-only, always read zero
// - rate field selects tap 2^15 to 2^18
// - reset selects slowest rate
// - selected tap also clocks watchdog
// - watchdog trips on eighth tap, seven to eight tap periods after clear
// - divide-by-eight prescaler feeds 15-stage counter
// - one count per eight oscillator cycles
// - power-on clears chain, cleared again after delay
// - four watchdog stages, gated by option bit
// - watchdog timeout resets whole chip
// - writing zero to clear bit clears watchdog
// - runs in run/wait/halt; stop clears it
// - stop-to-halt option keeps watchdog running
// - high voltage detect disables watchdog
package ctw_pkg;
  // byte addresses of the register words
  localparam logic [3:0] CTW_ADDR_CTRL  = 4'h0;
  localparam logic [3:0] CTW_ADDR_COUNT = 4'h4;
  localparam logic [3:0] CTW_ADDR_WDOG  = 4'h8;
  // control register bit positions
  localparam int CTW_BIT_OVF_FLAG = 7;
  localparam int CTW_BIT_PER_FLAG = 6;
  localparam int CTW_BIT_OVF_EN   = 5;
  localparam int CTW_BIT_PER_EN   = 4;
  localparam int CTW_BIT_OVF_CLR  = 3;
  localparam int CTW_BIT_PER_CLR  = 2;
  localparam int CTW_BIT_RATE_HI  = 1;
  localparam int CTW_BIT_RATE_LO  = 0;
  // watchdog register: clear bit position
  localparam int CTW_BIT_WD_CLEAR = 0;
  // reset value of the rate field
  localparam logic [1:0] CTW_RATE_RST = 2'h3;
  // counter structure
  localparam int CTW_PRESCALE  = 8;
  localparam int CTW_CHAIN_W   = 15;
  localparam int CTW_COUNT_W   = 8;
  localparam int CTW_TAP_BASE  = 12;
  localparam int CTW_WD_STAGES = 4;
  // startup delay, in bus cycles, and oscillator cycles per bus cycle
  localparam int CTW_OSC_PER_BUS    = 2;
  localparam int CTW_BOOT_SHORT_BUS = 16;
  localparam int CTW_BOOT_LONG_BUS  = 4064;
  localparam int CTW_BOOT_SHORT_CYC = CTW_BOOT_SHORT_BUS * CTW_OSC_PER_BUS;
endpackage

//--- rtl/ctw_prescaler.sv
// divide-by-eight prescaler giving a one-cycle count enable
`timescale 1ns/1ps
`default_nettype none
module ctw_prescaler
  import ctw_pkg::*;
#(
  parameter int DIV = CTW_PRESCALE  // oscillator cycles per count
) (
  input  wire logic mclk,  // oscillator clock
  input  wire logic srst,  // synchronous reset
  output logic      tick   // one-cycle count enable
);
  localparam int W = $clog2(DIV);

  // whole state of the divider
  typedef struct packed {
    logic [W-1:0] cnt;  // cycles since last enable
  } ctw_pre_type;

  ctw_pre_type st_q;  // registered state
  ctw_pre_type st_d;  // next state

  // count modulo DIV
  always_comb begin
    st_d = st_q;
    st_d.cnt = st_q.cnt + 1'b1;
    // wrap at the last cycle
    if (st_q.cnt == W'(DIV - 1)) begin
      st_d.cnt = '0;
    end
    // reset restarts the divider
    if (srst) begin
      st_d = '0;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  // enable once per DIV cycles
  assign tick = (st_q.cnt == W'(DIV - 1));
endmodule
`default_nettype wire

//--- rtl/ctw_watchdog.sv
// four-stage watchdog counter clocked by the periodic tap
`timescale 1ns/1ps
`default_nettype none
module ctw_watchdog
  import ctw_pkg::*;
#(
  parameter int WD_W = CTW_WD_STAGES  // watchdog stages
) (
  input  wire logic mclk,      // oscillator clock
  input  wire logic srst,      // synchronous reset
  input  wire logic tap_tick,  // selected periodic tap pulse
  input  wire logic active,    // enabled, not stopped, no high voltage
  input  wire logic wd_clear,  // software clear pulse
  output logic      trip       // chip reset request, held
);
  // last count before the trip
  localparam logic [WD_W-1:0] LAST = {1'b0, {(WD_W - 1){1'b1}}};

  // whole state of the watchdog
  typedef struct packed {
    logic [WD_W-1:0] cnt;   // tap periods since clear
    logic            trip;  // timeout reached
  } ctw_wd_type;

  ctw_wd_type st_q;  // registered state
  ctw_wd_type st_d;  // next state

  // count taps, trip on the eighth
  always_comb begin
    st_d = st_q;
    if (!active) begin
      // stopped or disabled: counter held clear
      st_d.cnt = '0;
    end else if (wd_clear) begin
      st_d.cnt = '0;
    end else if (tap_tick && !st_q.trip) begin
      st_d.cnt = st_q.cnt + 1'b1;
      // first tap lands 0..1 period after clear
      if (st_q.cnt == LAST) begin
        st_d.trip = 1'b1;
      end
    end
    // trip holds until the chip reset arrives
    if (srst) begin
      st_d = '0;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  assign trip = st_q.trip;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_wd_stop_clear: assert property (!active |=> st_q.cnt == '0)
    else $error("watchdog not cleared while inactive");
  a_wd_sw_clear: assert property (active && wd_clear |=> st_q.cnt == '0)
    else $error("watchdog clear ignored");
  a_wd_trip_eight: assert property (
    active && !wd_clear && tap_tick && st_q.cnt == LAST |=> trip)
    else $error("watchdog missed timeout");
  a_wd_no_early: assert property (
    !trip && !(tap_tick && st_q.cnt == LAST) |=> !trip)
    else $error("watchdog tripped early");
  c_wd_trip: cover property ($rose(trip));
endmodule
`default_nettype wire

//--- rtl/ctw_core_timer.sv
// core timer with periodic tap, watchdog and avalon-mm registers
`timescale 1ns/1ps
`default_nettype none
module ctw_core_timer
  import ctw_pkg::*;
#(
  parameter int BOOT_LONG_BUS = CTW_BOOT_LONG_BUS  // long startup, bus cycles
) (
  input  wire logic        mclk,              // oscillator clock
  input  wire logic        srst,              // power-on reset
  input  wire logic [3:0]  avs_address,       // byte address
  input  wire logic        avs_read,          // read request
  input  wire logic        avs_write,         // write request
  input  wire logic [31:0] avs_writedata,     // write data
  input  wire logic [3:0]  avs_byteenable,    // byte lanes
  output logic      [31:0] avs_readdata,      // read data
  output logic             avs_waitrequest,   // stall
  input  wire logic        opt_delay_long,    // long startup option
  input  wire logic        opt_wdog_enable,   // watchdog option
  input  wire logic        opt_stop_to_halt,  // stop-to-halt option
  input  wire logic        stop_mode,         // cpu executed stop
  input  wire logic        hv_detect,         // high voltage on prog pin
  output logic             overflow_irq,      // overflow request
  output logic             periodic_irq,      // periodic request
  output logic             boot_hold,         // chip held in startup
  output logic             wd_chip_reset,     // watchdog reset request
  output logic             stop_as_halt       // treat stop as halt
);
  // startup length in oscillator cycles
  localparam int BOOT_LONG_CYC = BOOT_LONG_BUS * CTW_OSC_PER_BUS;
  localparam int BW = $clog2(BOOT_LONG_CYC + 1);

  // startup or running, one-hot
  typedef enum logic [1:0] {
    CTW_PH_BOOT = 2'b01,
    CTW_PH_RUN  = 2'b10
  } ctw_phase_type;

  // whole state of the block
  typedef struct packed {
    ctw_phase_type          phase;     // startup or run
    logic [BW-1:0]          boot_cnt;  // startup cycles
    logic                   opt_taken; // options captured
    logic                   opt_long;  // long startup
    logic                   opt_wd;    // watchdog enabled
    logic                   opt_s2h;   // stop runs as halt
    logic [CTW_CHAIN_W-1:0] chain;     // timer stages
    logic                   ovf_flag;  // overflow flag
    logic                   per_flag;  // periodic flag
    logic                   ovf_en;    // overflow enable
    logic                   per_en;    // periodic enable
    logic [1:0]             rate;      // tap select
    logic                   ack;       // bus answer cycle
    logic [7:0]             rdata;     // read data
  } ctw_state_type;

  ctw_state_type st_q;  // registered state
  ctw_state_type st_d;  // next state

  logic       pre_tick;  // one count enable per eight cycles
  logic       running;   // startup finished
  logic       req;       // bus request present
  logic       wr_ok;     // write accepted this edge
  logic       wr_ctrl;   // accepted write to control
  logic       wr_wdog;   // accepted write to watchdog
  logic       wr_count;  // accepted write to counter
  logic       ovf_hit;   // low byte wraps this cycle
  logic       per_hit;   // selected tap becomes active
  logic       wd_active; // watchdog allowed to count
  logic       wd_clear;  // software watchdog clear
  logic       wd_trip;   // watchdog timeout
  logic [7:0] rd_val;    // read mux output
  logic [BW-1:0] boot_last; // last startup cycle

  // test whether the low stages of the tap are all ones
  function automatic logic tap_full(
    input logic [CTW_CHAIN_W-1:0] chain,
    input logic [1:0]             rate
  );
    logic [CTW_CHAIN_W-1:0] mask;
    mask = '0;
    for (int i = 0; i < CTW_CHAIN_W; i++) begin
      // stages below 12 + rate form the tap
      if (i < CTW_TAP_BASE + int'(rate)) begin
        mask[i] = 1'b1;
      end
    end
    return (chain & mask) == mask;
  endfunction

  // count enable from the prescaler
  ctw_prescaler #(
    .DIV (CTW_PRESCALE)
  ) u_pre (
    .mclk (mclk),
    .srst (srst),
    .tick (pre_tick)
  );

  // watchdog stages after the chain
  ctw_watchdog #(
    .WD_W (CTW_WD_STAGES)
  ) u_wd (
    .mclk     (mclk),
    .srst     (srst),
    .tap_tick (per_hit),
    .active   (wd_active),
    .wd_clear (wd_clear),
    .trip     (wd_trip)
  );

  // phase and event decode
  assign running = (st_q.phase == CTW_PH_RUN);
  assign ovf_hit = running && pre_tick
                && (st_q.chain[CTW_COUNT_W-1:0] == 8'hff);
  assign per_hit = running && pre_tick
                && tap_full(st_q.chain, st_q.rate);

  // bus decode: answer one cycle after the request
  // any request level opens a transfer
  assign req = avs_read || avs_write;
  // a write lands only on the answer edge, lane 0 enabled
  assign wr_ok = avs_write && st_q.ack && avs_byteenable[0];
  // per-register write strobes
  assign wr_ctrl = wr_ok && (avs_address == CTW_ADDR_CTRL);
  assign wr_wdog = wr_ok && (avs_address == CTW_ADDR_WDOG);
  // counter writes decode but no branch below uses them
  assign wr_count = wr_ok && (avs_address == CTW_ADDR_COUNT);

  // watchdog clear: writing zero to the clear bit
  assign wd_clear = wr_wdog && !avs_writedata[CTW_BIT_WD_CLEAR];

  // watchdog gating: option, high voltage, stop
  always_comb begin
    wd_active = running && st_q.opt_wd;
    // high voltage on the programming pin
    if (hv_detect) begin
      wd_active = 1'b0;
    end
    // a real stop clears and halts the watchdog
    if (stop_mode && !st_q.opt_s2h) begin
      wd_active = 1'b0;
    end
  end

  // read multiplexer
  always_comb begin
    rd_val = 8'h00;
    unique case (avs_address)
      CTW_ADDR_CTRL: begin
        rd_val[CTW_BIT_OVF_FLAG] = st_q.ovf_flag;
        rd_val[CTW_BIT_PER_FLAG] = st_q.per_flag;
        rd_val[CTW_BIT_OVF_EN] = st_q.ovf_en;
        rd_val[CTW_BIT_PER_EN] = st_q.per_en;
        // clear bits stay zero
        rd_val[CTW_BIT_RATE_HI] = st_q.rate[1];
        rd_val[CTW_BIT_RATE_LO] = st_q.rate[0];
      end
      CTW_ADDR_COUNT: begin
        rd_val = st_q.chain[CTW_COUNT_W-1:0];
      end
      // watchdog register and unmapped read zero
      default: begin
        rd_val = 8'h00;
      end
    endcase
  end

  // startup length from the captured option
  assign boot_last = st_q.opt_long ? BW'(BOOT_LONG_CYC - 1)
                                   : BW'(CTW_BOOT_SHORT_CYC - 1);

  // next-state logic
  always_comb begin
    st_d = st_q;

    // bus handshake: one wait cycle, then answer
    st_d.ack = req && !st_q.ack;
    if (req && !st_q.ack) begin
      st_d.rdata = rd_val;
    end

    // counter chain runs from power-on
    if (pre_tick) begin
      st_d.chain = st_q.chain + 1'b1;
    end

    // startup sequencing
    unique case (st_q.phase)
      CTW_PH_BOOT: begin
        // capture option straps after release
        if (!st_q.opt_taken) begin
          st_d.opt_taken = 1'b1;
          st_d.opt_long = opt_delay_long;
          st_d.opt_wd = opt_wdog_enable;
          st_d.opt_s2h = opt_stop_to_halt;
        end
        st_d.boot_cnt = st_q.boot_cnt + 1'b1;
        // delay over: clear the chain again
        if (st_q.opt_taken && st_q.boot_cnt >= boot_last) begin
          st_d.phase = CTW_PH_RUN;
          st_d.chain = '0;
        end
      end
      CTW_PH_RUN: begin
        // startup count frozen until the next power-on
        st_d.boot_cnt = st_q.boot_cnt;
      end
      // illegal code: restart startup
      default: begin
        st_d.phase = CTW_PH_BOOT;
      end
    endcase

    // control writes; flags are not writable
    if (wr_ctrl) begin
      // enables follow the written bits
      st_d.ovf_en = avs_writedata[CTW_BIT_OVF_EN];
      st_d.per_en = avs_writedata[CTW_BIT_PER_EN];
      // new rate takes effect at once, watchdog count kept
      st_d.rate[1] = avs_writedata[CTW_BIT_RATE_HI];
      st_d.rate[0] = avs_writedata[CTW_BIT_RATE_LO];
    end

    // overflow flag: set wins over clear
    if (wr_ctrl && avs_writedata[CTW_BIT_OVF_CLR]) begin
      st_d.ovf_flag = 1'b0;
    end
    if (ovf_hit) begin
      st_d.ovf_flag = 1'b1;
    end

    // periodic flag: set wins over clear
    if (wr_ctrl && avs_writedata[CTW_BIT_PER_CLR]) begin
      st_d.per_flag = 1'b0;
    end
    if (per_hit) begin
      st_d.per_flag = 1'b1;
    end

    // power-on: everything clear, slowest rate
    if (srst) begin
      st_d = '0;
      st_d.phase = CTW_PH_BOOT;
      st_d.rate = CTW_RATE_RST;
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    st_q <= st_d;
  end

  // outputs
  // stall only in the first cycle of a request
  assign avs_waitrequest = req && !st_q.ack;
  // registered byte, upper lanes zero
  assign avs_readdata = {24'h00_0000, st_q.rdata};
  // requests are flag and enable together
  assign overflow_irq = st_q.ovf_flag && st_q.ovf_en;
  assign periodic_irq = st_q.per_flag && st_q.per_en;
  // chip stays held until the startup delay ends
  assign boot_hold = (st_q.phase != CTW_PH_RUN);
  // trip is held inside the watchdog until power-on
  assign wd_chip_reset = wd_trip;
  // captured strap, fixed until the next power-on
  assign stop_as_halt = st_q.opt_s2h;

  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  a_ovf_set_wrap: assert property (
    running && pre_tick && st_q.chain[7:0] == 8'hff |=> st_q.ovf_flag)
    else $error("overflow flag missed a wrap");

  a_ovf_irq_follow: assert property (
    wr_ctrl && avs_writedata[CTW_BIT_OVF_EN]
      && !avs_writedata[CTW_BIT_OVF_CLR] && st_q.ovf_flag
    |=> overflow_irq)
    else $error("overflow request not raised");

  a_ovf_clear_one: assert property (
    wr_ctrl && avs_writedata[CTW_BIT_OVF_CLR] && !ovf_hit
    |=> !st_q.ovf_flag)
    else $error("overflow flag not cleared");

  a_ovf_keep_zero: assert property (
    wr_ctrl && !avs_writedata[CTW_BIT_OVF_CLR] && st_q.ovf_flag
    |=> st_q.ovf_flag)
    else $error("overflow flag lost on zero write");

  a_per_set_tap: assert property (
    per_hit |=> st_q.per_flag && (periodic_irq == st_q.per_en))
    else $error("periodic flag missed the tap");

  a_per_clear_one: assert property (
    wr_ctrl && avs_writedata[CTW_BIT_PER_CLR] && !per_hit
    |=> !st_q.per_flag)
    else $error("periodic flag not cleared");

  a_clr_bits_zero: assert property (
    avs_read && !st_q.ack && avs_address == CTW_ADDR_CTRL
    |=> avs_readdata[3:2] == 2'b00)
    else $error("clear bits read nonzero");

  a_rate_reset: assert property (
    $past(srst) |-> st_q.rate == 2'b11 && !st_q.ovf_en && !st_q.per_flag)
    else $error("reset state wrong");

  a_prescale_gap: assert property (
    pre_tick |=> !pre_tick [*7] ##1 pre_tick)
    else $error("prescaler period not eight");

  a_boot_clear: assert property (
    $fell(boot_hold) |-> st_q.chain == '0)
    else $error("chain not cleared at startup end");

  a_count_ro: assert property (
    wr_count && running && !pre_tick |=> $stable(st_q.chain)
      && $stable(st_q.ovf_flag))
    else $error("counter write changed state");

  a_per_keep_zero: assert property (
    wr_ctrl && !avs_writedata[CTW_BIT_PER_CLR] && st_q.per_flag
    |=> st_q.per_flag)
    else $error("periodic flag lost on zero write");

  a_boot_quiet: assert property (
    boot_hold |=> !st_q.ovf_flag && !st_q.per_flag)
    else $error("flag set during startup");

  a_wd_opt_off: assert property (
    running && !st_q.opt_wd |-> !wd_chip_reset)
    else $error("watchdog reset with option off");

  // main scenarios reached
  c_ovf_irq: cover property ($rose(overflow_irq));
  c_per_irq: cover property ($rose(periodic_irq));
  c_boot_end: cover property ($fell(boot_hold));
  c_wd_reset: cover property ($rose(wd_chip_reset));
endmodule
`default_nettype wire

//--- tb/ctw_core_timer_tb.sv
// self-checking bench for the core timer with watchdog
`timescale 1ns/1ps
`default_nettype none
module ctw_core_timer_tb;
  import ctw_pkg::*;
  localparam int BOOT_BUS = 20;  // shortened long startup, bus cycles
  // one bus access and the byte it should read back
  typedef struct {
    logic       wr;
    logic [3:0] addr;
    logic [7:0] data;
    logic [3:0] be;
    logic [7:0] exp;
  } ctw_row_type;
  logic        mclk;              // oscillator clock
  logic        srst;              // power-on reset
  logic [3:0]  avs_address;       // byte address
  logic        avs_read;          // read request
  logic        avs_write;         // write request
  logic [31:0] avs_writedata;     // write data
  logic [3:0]  avs_byteenable;    // byte lanes
  logic [31:0] avs_readdata;      // read data
  logic        avs_waitrequest;   // stall
  logic        opt_delay_long;    // long startup option
  logic        opt_wdog_enable;   // watchdog option
  logic        opt_stop_to_halt;  // stop-to-halt option
  logic        stop_mode;         // cpu in stop
  logic        hv_detect;         // high voltage on programming pin
  logic        overflow_irq;      // overflow request
  logic        periodic_irq;      // periodic request
  logic        boot_hold;         // startup in progress
  logic        wd_chip_reset;     // watchdog reset request
  logic        stop_as_halt;      // stop treated as halt
  int          bad_count;         // mismatches seen
  int          check_count;       // comparisons made
  logic [31:0] rd;                // read data of last access
  logic [31:0] rd2;               // second read data
  time         t1;                // first event time
  time         t2;                // second event time
  ctw_row_type rows [16];         // ordinary register cases

  ctw_core_timer #(
    .BOOT_LONG_BUS(BOOT_BUS)
  ) u_ctw_core_timer (
    .mclk            (mclk),
    .srst            (srst),
    .avs_address     (avs_address),
    .avs_read        (avs_read),
    .avs_write       (avs_write),
    .avs_writedata   (avs_writedata),
    .avs_byteenable  (avs_byteenable),
    .avs_readdata    (avs_readdata),
    .avs_waitrequest (avs_waitrequest),
    .opt_delay_long  (opt_delay_long),
    .opt_wdog_enable (opt_wdog_enable),
    .opt_stop_to_halt(opt_stop_to_halt),
    .stop_mode       (stop_mode),
    .hv_detect       (hv_detect),
    .overflow_irq    (overflow_irq),
    .periodic_irq    (periodic_irq),
    .boot_hold       (boot_hold),
    .wd_chip_reset   (wd_chip_reset),
    .stop_as_halt    (stop_as_halt)
  );

  // free-running 100 MHz clock
  always #5 mclk = ~mclk;

  // compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // closing verdict, the single exit of the run
  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one avalon access: hold until a rising edge samples waitrequest low
  task automatic bus(input logic wr, input logic [3:0] addr, input logic [7:0] data,
                     input logic [3:0] be, output logic [31:0] rdata);
    @(posedge mclk);
    avs_read       <= !wr;
    avs_write      <= wr;
    avs_address    <= addr;
    avs_writedata  <= {24'h00_0000, data};
    avs_byteenable <= be;
    // only the bench watchdog ends this wait
    do begin
      @(posedge mclk);
    end while (avs_waitrequest !== 1'b0);
    // answer edge: data taken, request released
    rdata = avs_readdata;
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
  endtask

  // wait for a request line to go high, bounded; sel 0 overflow, 1 periodic
  task automatic wait_high(input int sel, input int lim, output time t);
    int n;
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while ((sel == 0 ? overflow_irq : periodic_irq) !== 1'b1 && n < lim);
    if (n >= lim) bad_count++;
    t = $time;
  endtask

  // reset with given options, then time the startup hold
  task automatic power_up(input logic long_dly, input logic to_halt, input int cyc);
    int n;
    n = 0;
    @(posedge mclk);
    srst             <= 1'b1;
    opt_delay_long   <= long_dly;
    opt_stop_to_halt <= to_halt;
    repeat (6) @(posedge mclk);
    check({boot_hold, overflow_irq, periodic_irq, wd_chip_reset}, 32'h0000_0008);
    srst <= 1'b0;
    do begin
      @(negedge mclk);
      n++;
    end while (boot_hold !== 1'b0 && n < 200);
    check(32'((n >= cyc) && (n <= cyc + 3)), 32'h0000_0001);
    check(stop_as_halt, to_halt);
    bus(1'b0, CTW_ADDR_COUNT, 8'h00, 4'hF, rd);
    check(32'(rd < 2), 32'h0000_0001);
    bus(1'b0, CTW_ADDR_CTRL, 8'h00, 4'hF, rd);
    check(rd, 32'h0000_0003);
  endtask

  // hang guard, well past the expected run length
  initial begin
    #950_000;
    bad_count++;
    end_sim();
  end

  // main sequence
  initial begin
    mclk = 1'b0;
    srst = 1'b1;
    avs_address = 4'h0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    opt_delay_long = 1'b0;
    opt_wdog_enable = 1'b1;
    opt_stop_to_halt = 1'b1;
    stop_mode = 1'b0;
    hv_detect = 1'b0;
    bad_count = 0;
    check_count = 0;
    // wr, address, data, lanes, expected read byte
    rows = '{
      '{1'b1, 4'h8, 8'h00, 4'hF, 8'h00},  // watchdog clear before rate change
      '{1'b1, 4'h0, 8'hFC, 4'hF, 8'h00},  // flags, enables, clears, rate 0
      '{1'b0, 4'h0, 8'h00, 4'hF, 8'h30},  // flags stay clear, clears read 0
      '{1'b1, 4'h0, 8'h01, 4'h0, 8'h00},  // lane 0 off: ignored
      '{1'b0, 4'h0, 8'h00, 4'hF, 8'h30},
      '{1'b1, 4'h0, 8'h12, 4'h1, 8'h00},  // rate 2, periodic enable only
      '{1'b0, 4'h0, 8'h00, 4'hF, 8'h12},
      '{1'b1, 4'h0, 8'h21, 4'h1, 8'h00},  // rate 1, overflow enable only
      '{1'b0, 4'h0, 8'h00, 4'hF, 8'h21},
      '{1'b0, 4'h8, 8'h00, 4'hF, 8'h00},  // watchdog reads 0
      '{1'b1, 4'hC, 8'hFF, 4'hF, 8'h00},  // unmapped write
      '{1'b0, 4'hC, 8'h00, 4'hF, 8'h00},  // unmapped read
      '{1'b1, 4'h4, 8'hFF, 4'hF, 8'h00},  // counter write ignored
      '{1'b0, 4'h0, 8'h00, 4'hF, 8'h21},
      '{1'b1, 4'h8, 8'h00, 4'hF, 8'h00},
      '{1'b1, 4'h0, 8'h30, 4'hF, 8'h00}   // rate 0, both enables
    };
    power_up(1'b0, 1'b1, CTW_BOOT_SHORT_CYC);
    foreach (rows[i]) begin
      bus(rows[i].wr, rows[i].addr, rows[i].data, rows[i].be, rd);
      if (!rows[i].wr) check(rd, {24'h00_0000, rows[i].exp});
    end
    check({overflow_irq, periodic_irq}, 32'h0000_0000);
    // reads whose sampling edges lie eight cycles apart step by one
    bus(1'b0, CTW_ADDR_COUNT, 8'h00, 4'hF, rd);
    repeat (5) @(posedge mclk);
    bus(1'b0, CTW_ADDR_COUNT, 8'h00, 4'hF, rd2);
    check(rd2, {24'h00_0000, rd[7:0] + 8'h01});
    // overflow: set, direct and zero writes ignored, mask, clear, period
    wait_high(0, 2100, t1);
    bus(1'b0, CTW_ADDR_CTRL, 8'h00, 4'hF, rd);
    check(rd, 32'h0000_00B0);
    bus(1'b1, CTW_ADDR_CTRL, 8'h70, 4'hF, rd);
    bus(1'b0, CTW_ADDR_CTRL, 8'h00, 4'hF, rd);
    check(rd, 32'h0000_00B0);
    bus(1'b1, CTW_ADDR_CTRL, 8'h10, 4'hF, rd);
    bus(1'b0, CTW_ADDR_CTRL, 8'h00, 4'hF, rd);
    check({overflow_irq, rd[7:0]}, 32'h0000_0090);
    bus(1'b1, CTW_ADDR_CTRL, 8'h38, 4'hF, rd);
    bus(1'b0, CTW_ADDR_CTRL, 8'h00, 4'hF, rd);
    check({overflow_irq, rd[7:0]}, 32'h0000_0030);
    wait_high(0, 2100, t2);
    check(32'((t2 - t1) / 10), 32'h0000_0800);
    // periodic at rate 0, stop converted to halt meanwhile
    bus(1'b1, CTW_ADDR_WDOG, 8'h00, 4'hF, rd);
    stop_mode <= 1'b1;
    wait_high(1, 33000, t1);
    bus(1'b0, CTW_ADDR_CTRL, 8'h00, 4'hF, rd);
    check(rd & 32'h0000_0040, 32'h0000_0040);
    bus(1'b1, CTW_ADDR_CTRL, 8'h34, 4'hF, rd);
    bus(1'b0, CTW_ADDR_CTRL, 8'h00, 4'hF, rd);
    check({periodic_irq, rd[6]}, 32'h0000_0000);
    bus(1'b1, CTW_ADDR_WDOG, 8'h00, 4'hF, rd);
    wait_high(1, 33000, t2);
    check(32'((t2 - t1) / 10), 32'h0000_8000);
    // a full trip at rate 0 is too long to run; cleared watchdog must stay quiet
    check(wd_chip_reset, 32'h0000_0000);
    @(posedge mclk);
    stop_mode <= 1'b0;
    hv_detect <= 1'b1;
    // second reset mid-run with the long startup option
    power_up(1'b1, 1'b0, 2 * BOOT_BUS);
    hv_detect <= 1'b0;
    check({overflow_irq, periodic_irq, wd_chip_reset}, 32'h0000_0000);
    end_sim();
  end
endmodule
`default_nettype wire
